// ### inc/diskette_regs.vh
// register map, field positions and timing counts of the diskette interface
// assumes a 50 MHz system clock and a 32-bit AHB-Lite register bus
`ifndef DISKETTE_REGS_VH
`define DISKETTE_REGS_VH
`define CLK_MHZ         50
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_STEP        8'h08
`define REG_DATA        8'h0c
`define CTRL_RESET      11'h000
`define CB_UNIT         0
`define CB_SPINDLE      1
`define CB_DENS144      2
`define CB_HEAD1        3
`define CB_OUTER        4
`define CB_WRITE        5
`define CB_BURST        6
`define CB_DMA          7
`define CB_RATE_LO      8
`define CB_RATE_HI      9
`define HTRANS_NONSEQ   2'b10
`define RATE_2M_NS      500
`define RATE_1M_NS      1000
`define RATE_500K_NS    2000
`define RATE_250K_NS    4000
`define BIT_2M_CYC      (`RATE_2M_NS * `CLK_MHZ / 1000)
`define BIT_1M_CYC      (`RATE_1M_NS * `CLK_MHZ / 1000)
`define BIT_500K_CYC    (`RATE_500K_NS * `CLK_MHZ / 1000)
`define BIT_250K_CYC    (`RATE_250K_NS * `CLK_MHZ / 1000)
`define DIR_SETUP_NS    1000
`define STEP_WIDTH_NS   1000
`define STEP_GAP_US     3000
`define DIR_SETUP_CYC   ((`DIR_SETUP_NS * `CLK_MHZ + 999) / 1000)
`define STEP_WIDTH_CYC  ((`STEP_WIDTH_NS * `CLK_MHZ + 999) / 1000)
`define STEP_GAP_CYC    (`STEP_GAP_US * `CLK_MHZ)
`define FIFO_AW         4
`define BURST_LEVEL     5'h08
`endif

// ### rtl/byte_fifo.v
// sixteen-byte transfer buffer with first-word fall-through head
// assumes push is ignored when full unless a pop is taken in the same cycle, and pop is ignored when empty
`timescale 1ns/100ps
module byte_fifo #(
    parameter W  = 8,
    parameter AW = 4
) (
    input  wire          clk,
    input  wire          rstn,
    input  wire          push,
    input  wire [W-1:0]  wdata,
    input  wire          pop,
    output wire [W-1:0]  rdata,
    output reg  [AW:0]   count,
    output wire          full,
    output wire          empty
);
    reg  [W-1:0]  mem [0:(1<<AW)-1];
    reg  [AW-1:0] wrPtr;
    reg  [AW-1:0] rdPtr;
    wire          doPush;
    wire          doPop;

    assign full   = count[AW];
    assign empty  = (count == {(AW+1){1'b0}});
    assign doPop  = pop & ~empty;
    assign doPush = push & (~full | doPop);
    assign rdata  = mem[rdPtr];

    always @(posedge clk) begin
        if (doPush)
            mem[wrPtr] <= wdata;
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrPtr <= {AW{1'b0}};
            rdPtr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (doPush)
                wrPtr <= wrPtr + 1'b1;
            if (doPop)
                rdPtr <= rdPtr + 1'b1;
            if (doPush & ~doPop)
                count <= count + 1'b1;
            else if (doPop & ~doPush)
                count <= count - 1'b1;
        end
    end
endmodule

// ### rtl/step_sequencer.v
// head stepping sequencer: direction setup, step pulse, step gap
// assumes start is a one-cycle pulse taken only while idle
`timescale 1ns/100ps
module step_sequencer #(
    parameter SETUP_CYC = 50,
    parameter WIDTH_CYC = 50,
    parameter GAP_CYC   = 150000
) (
    input  wire       clk,
    input  wire       rstn,
    input  wire       start,
    input  wire [7:0] steps,
    input  wire       towardOuter,
    output reg        stepN,
    output reg        seekDir,
    output reg        busy
);
    localparam IDLE  = 2'd0;
    localparam SETUP = 2'd1;
    localparam PULSE = 2'd2;
    localparam GAP   = 2'd3;
    localparam integer SETUP_I  = SETUP_CYC - 1;
    localparam integer WIDTH_I  = WIDTH_CYC - 1;
    localparam integer GAP_I    = GAP_CYC - 1;
    localparam [23:0] SETUP_M1 = SETUP_I[23:0];
    localparam [23:0] WIDTH_M1 = WIDTH_I[23:0];
    localparam [23:0] GAP_M1   = GAP_I[23:0];

    reg [1:0]  state;
    reg [23:0] cnt;
    reg [7:0]  left;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state   <= IDLE;
            cnt     <= 24'h000000;
            left    <= 8'h00;
            stepN   <= 1'b1;
            seekDir <= 1'b0;
            busy    <= 1'b0;
        end else begin
            case (state)
                IDLE: begin
                    if (start && steps != 8'h00) begin
                        seekDir <= towardOuter;
                        left    <= steps;
                        cnt     <= SETUP_M1;
                        busy    <= 1'b1;
                        state   <= SETUP;
                    end
                end
                SETUP: begin
                    if (cnt == 24'h000000) begin
                        stepN <= 1'b0;
                        cnt   <= WIDTH_M1;
                        state <= PULSE;
                    end else
                        cnt <= cnt - 1'b1;
                end
                PULSE: begin
                    if (cnt == 24'h000000) begin
                        stepN <= 1'b1;
                        left  <= left - 1'b1;
                        cnt   <= GAP_M1;
                        state <= GAP;
                    end else
                        cnt <= cnt - 1'b1;
                end
                GAP: begin
                    if (cnt != 24'h000000)
                        cnt <= cnt - 1'b1;
                    else if (left == 8'h00) begin
                        busy  <= 1'b0;
                        state <= IDLE;
                    end else begin
                        stepN <= 1'b0;
                        cnt   <= WIDTH_M1;
                        state <= PULSE;
                    end
                end
                default: state <= IDLE;
            endcase
        end
    end
endmodule

// ### rtl/diskette_drive_interface.v
// diskette drive interface: AHB-Lite registers, drive control lines,
// serial write/read streams, transfer FIFO and DMA request/acknowledge
// assumes single clock mclk at 50 MHz; drive pins are asynchronous
//
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "diskette_regs.vh"

module diskette_drive_interface #(
    parameter STEP_GAP_CYC = `STEP_GAP_CYC,
    parameter FIFO_AW      = `FIFO_AW
) (
    input  wire        mclk,
    input  wire        rstn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg         hresp,
    output reg  [31:0] hrdata,
    output reg         dmaReq,
    input  wire        dmaAck,
    input  wire [7:0]  dmaWData,
    output reg  [7:0]  dmaRData,
    output reg         unitSelN,
    output reg         spindleRunN,
    output reg         densityMode,
    output reg         sideSel,
    output wire        seekDir,
    output wire        stepN,
    output reg         writeEnableN,
    output reg         writeStream,
    input  wire        rotationMarkN,
    input  wire        hiDensityN,
    input  wire        outerCylFlagN,
    input  wire        mediaLockN,
    input  wire        readStream,
    input  wire        mediaSwappedN,
    input  wire        driveId
);
    reg  [10:0]        ctrl;
    reg  [6:0]         syncA;
    reg  [6:0]         syncB;
    reg                markPrev;
    reg  [7:0]         revCount;
    reg                idTaken;
    reg                idLatched;
    reg  [1:0]         idWait;
    reg                wrPend;
    reg  [7:0]         wrAddr;
    reg                stepGo;
    reg  [7:0]         stepCount;
    reg  [7:0]         bitCnt;
    reg  [7:0]         shReg;
    reg  [3:0]         shCnt;
    reg                modePrev;
    reg                overrun;
    reg                underrun;
    wire               rdSync;
    wire               markN;
    wire               hiDensN;
    wire               outerN;
    wire               lockN;
    wire               swapN;
    wire               idSync;
    wire               busSel;
    wire               busRead;
    wire               writeMode;
    wire               readMode;
    wire               bitTick;
    wire               serPop;
    wire               serPush;
    wire [7:0]         serByte;
    wire               hostPush;
    wire               hostPop;
    wire               dmaPush;
    wire               dmaPop;
    wire               stepBusy;
    wire               statusRead;
    wire               fifoPush;
    wire [7:0]         fifoWData;
    wire               fifoPop;
    wire [7:0]         fifoHead;
    wire [FIFO_AW:0]   fifoCount;
    wire               fifoFull;
    wire               fifoEmpty;

    localparam integer CELL_2M   = `BIT_2M_CYC;
    localparam integer CELL_1M   = `BIT_1M_CYC;
    localparam integer CELL_500K = `BIT_500K_CYC;
    localparam integer CELL_250K = `BIT_250K_CYC;

    // bit-cell length in clock cycles for the selected rate
    function [7:0] ratePeriod;
        input [1:0] sel;
        begin
            case (sel)
                2'd0:    ratePeriod = CELL_2M[7:0];
                2'd1:    ratePeriod = CELL_1M[7:0];
                2'd2:    ratePeriod = CELL_500K[7:0];
                default: ratePeriod = CELL_250K[7:0];
            endcase
        end
    endfunction

    // two-stage synchronisers for every drive input
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            syncA <= 7'h7f;
            syncB <= 7'h7f;
        end else begin
            syncA <= {driveId, mediaSwappedN, readStream, mediaLockN,
                      outerCylFlagN, hiDensityN, rotationMarkN};
            syncB <= syncA;
        end
    end

    assign markN   = syncB[0];
    assign hiDensN = syncB[1];
    assign outerN  = syncB[2];
    assign lockN   = syncB[3];
    assign rdSync  = syncB[4];
    assign swapN   = syncB[5];
    assign idSync  = syncB[6];

    // revolution counter on each rotation mark falling edge
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            markPrev <= 1'b1;
            revCount <= 8'h00;
        end else begin
            markPrev <= markN;
            if (markPrev & ~markN)
                revCount <= revCount + 1'b1;
        end
    end

    // drive type captured once, after the synchroniser has filled
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            idTaken   <= 1'b0;
            idLatched <= 1'b0;
            idWait    <= 2'd0;
        end else if (!idTaken) begin
            if (idWait == 2'd2) begin
                idTaken   <= 1'b1;
                idLatched <= idSync;
            end else
                idWait <= idWait + 1'b1;
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY
    assign busSel  = hsel & hready & htrans[1];
    assign busRead = busSel & ~hwrite;
    assign statusRead = busRead & (haddr[7:0] == `REG_STATUS);

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wrPend    <= 1'b0;
            wrAddr    <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wrPend    <= busSel & hwrite;
            if (busSel & hwrite)
                wrAddr <= haddr[7:0];
        end
    end

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctrl      <= `CTRL_RESET;
            stepGo    <= 1'b0;
            stepCount <= 8'h00;
        end else begin
            stepGo <= 1'b0;
            if (wrPend && wrAddr == `REG_CTRL)
                ctrl <= hwdata[10:0];
            if (wrPend && wrAddr == `REG_STEP && ctrl[`CB_UNIT] && !stepBusy) begin
                stepGo    <= 1'b1;
                stepCount <= hwdata[7:0];
            end
        end
    end

    always @(posedge mclk or negedge rstn) begin
        if (!rstn)
            hrdata <= 32'h00000000;
        else if (busRead) begin
            case (haddr[7:0])
                `REG_CTRL:   hrdata <= {21'h000000, ctrl};
                `REG_STATUS: hrdata <= {revCount, 1'b0, fifoEmpty, fifoFull,
                                        fifoCount, 6'h00, underrun, overrun,
                                        idLatched, writeMode, stepBusy,
                                        ~swapN, ~hiDensN, ~lockN, ~outerN,
                                        ~markN};
                `REG_STEP:   hrdata <= {24'h000000, stepCount};
                `REG_DATA:   hrdata <= {24'h000000, fifoEmpty ? 8'h00 : fifoHead};
                default:     hrdata <= 32'h00000000;
            endcase
        end
    end

    // drive control lines
    assign writeMode = ctrl[`CB_WRITE] & ctrl[`CB_UNIT] & lockN;
    assign readMode  = ctrl[`CB_UNIT] & ~ctrl[`CB_WRITE];

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            unitSelN     <= 1'b1;
            spindleRunN  <= 1'b1;
            densityMode  <= 1'b0;
            sideSel      <= 1'b1;
            writeEnableN <= 1'b1;
        end else begin
            unitSelN     <= ~ctrl[`CB_UNIT];
            spindleRunN  <= ~ctrl[`CB_SPINDLE];
            densityMode  <= ctrl[`CB_DENS144];
            sideSel      <= ~ctrl[`CB_HEAD1];
            writeEnableN <= ~writeMode;
        end
    end

    step_sequencer #(
        .SETUP_CYC (`DIR_SETUP_CYC),
        .WIDTH_CYC (`STEP_WIDTH_CYC),
        .GAP_CYC   (STEP_GAP_CYC)
    ) u_step (
        .clk         (mclk),
        .rstn        (rstn),
        .start       (stepGo),
        .steps       (stepCount),
        .towardOuter (ctrl[`CB_OUTER]),
        .stepN       (stepN),
        .seekDir     (seekDir),
        .busy        (stepBusy)
    );

    // bit-cell divider
    assign bitTick = (bitCnt == ratePeriod(ctrl[`CB_RATE_HI:`CB_RATE_LO]) - 8'h01);

    always @(posedge mclk or negedge rstn) begin
        if (!rstn)
            bitCnt <= 8'h00;
        else if (bitTick || modePrev != writeMode)
            bitCnt <= 8'h00;
        else
            bitCnt <= bitCnt + 1'b1;
    end

    // serialiser for writing, deserialiser for reading
    assign serPop  = bitTick & writeMode & (shCnt == 4'h0) & ~fifoEmpty;
    assign serByte = {shReg[6:0], rdSync};
    assign serPush = bitTick & readMode & (shCnt == 4'h7);

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            shReg       <= 8'h00;
            shCnt       <= 4'h0;
            modePrev    <= 1'b0;
            writeStream <= 1'b0;
        end else begin
            modePrev <= writeMode;
            if (modePrev != writeMode) begin
                shCnt       <= 4'h0;
                writeStream <= 1'b0;
            end else if (bitTick && writeMode) begin
                if (shCnt != 4'h0) begin
                    writeStream <= shReg[7];
                    shReg       <= {shReg[6:0], 1'b0};
                    shCnt       <= shCnt - 1'b1;
                end else if (!fifoEmpty) begin
                    writeStream <= fifoHead[7];
                    shReg       <= {fifoHead[6:0], 1'b0};
                    shCnt       <= 4'h7;
                end else
                    writeStream <= 1'b0;
            end else if (bitTick && readMode) begin
                shReg <= serByte;
                shCnt <= (shCnt == 4'h7) ? 4'h0 : shCnt + 1'b1;
            end
        end
    end

    // overrun and underrun flags; a new event wins over the read that clears
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            overrun  <= 1'b0;
            underrun <= 1'b0;
        end else begin
            if (serPush & fifoFull)
                overrun <= 1'b1;
            else if (statusRead)
                overrun <= 1'b0;
            if (bitTick & writeMode & (shCnt == 4'h0) & fifoEmpty)
                underrun <= 1'b1;
            else if (statusRead)
                underrun <= 1'b0;
        end
    end

    // FIFO sources and sinks follow the transfer direction
    assign dmaPush  = dmaAck & writeMode & ctrl[`CB_DMA];
    assign dmaPop   = dmaAck & readMode & ctrl[`CB_DMA] & ~fifoEmpty;
    assign hostPush = wrPend & (wrAddr == `REG_DATA) & ~dmaPush & ~readMode;
    assign hostPop  = busRead & (haddr[7:0] == `REG_DATA) & ~writeMode;
    assign fifoPush = dmaPush | hostPush | serPush;
    assign fifoWData = dmaPush ? dmaWData : (serPush ? serByte : hwdata[7:0]);
    assign fifoPop  = serPop | dmaPop | hostPop;

    byte_fifo #(
        .W  (8),
        .AW (FIFO_AW)
    ) u_fifo (
        .clk   (mclk),
        .rstn  (rstn),
        .push  (fifoPush),
        .wdata (fifoWData),
        .pop   (fifoPop),
        .rdata (fifoHead),
        .count (fifoCount),
        .full  (fifoFull),
        .empty (fifoEmpty)
    );

    // DMA request: burst waits for half a FIFO, non-burst asks per byte
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dmaReq   <= 1'b0;
            dmaRData <= 8'h00;
        end else begin
            if (!ctrl[`CB_DMA])
                dmaReq <= 1'b0;
            else if (writeMode)
                dmaReq <= ctrl[`CB_BURST] ? (fifoCount <= `BURST_LEVEL) : ~fifoFull;
            else if (readMode)
                dmaReq <= ctrl[`CB_BURST] ? (fifoCount >= `BURST_LEVEL) : ~fifoEmpty;
            else
                dmaReq <= 1'b0;
            if (dmaPop)
                dmaRData <= fifoHead;
        end
    end
endmodule

// ### tb/diskette_checker_properties.sv
// port checker for the diskette drive interface
// assumes binding to the top module, single clock mclk
`timescale 1ns/100ps
module diskette_checker (
    input wire       mclk,
    input wire       rstn,
    input wire       hsel,
    input wire [1:0] htrans,
    input wire       hwrite,
    input wire       hready,
    input wire       unitSelN,
    input wire       spindleRunN,
    input wire       densityMode,
    input wire       sideSel,
    input wire       seekDir,
    input wire       stepN,
    input wire       writeEnableN,
    input wire       mediaLockN
);
    int lowCnt;
    // counts cycles of the step pulse
    always @(posedge mclk or negedge rstn)
        if (!rstn)
            lowCnt <= 0;
        else
            lowCnt <= stepN ? 0 : lowCnt + 1;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_dirHold; (!stepN || !$past(stepN)) |-> $stable(seekDir); endproperty
    a_dirHold: assert property (p_dirHold) else $error("seekDir moved in a step");
    property p_dirSetup; $fell(stepN) |-> seekDir == $past(seekDir, 8); endproperty
    a_dirSetup: assert property (p_dirSetup) else $error("seekDir not set up");
    property p_width; $rose(stepN) |-> lowCnt == 50; endproperty
    a_width: assert property (p_width) else $error("step pulse width wrong");
    property p_gap; $rose(stepN) |-> stepN [*8]; endproperty
    a_gap: assert property (p_gap) else $error("step gap too short");
    property p_lock; !mediaLockN [*4] |-> writeEnableN; endproperty
    a_lock: assert property (p_lock) else $error("write on locked media");
    property p_wUnit; !writeEnableN |-> !unitSelN; endproperty
    a_wUnit: assert property (p_wUnit) else $error("write while deselected");
    property p_sUnit; $fell(stepN) |-> !unitSelN; endproperty
    a_sUnit: assert property (p_sUnit) else $error("step while deselected");
    property p_pins;
        $changed({unitSelN, spindleRunN, densityMode, sideSel})
            |-> $past(hsel && hready && htrans[1] && hwrite, 3);
    endproperty
    a_pins: assert property (p_pins) else $error("control pin moved alone");
endmodule
bind diskette_drive_interface diskette_checker chk (.mclk, .rstn, .hsel, .htrans,
    .hwrite, .hready, .unitSelN, .spindleRunN, .densityMode, .sideSel, .seekDir,
    .stepN, .writeEnableN, .mediaLockN);

// ### tb/drive_model.sv
// behavioural diskette drive on the far side of the cable
// assumes bench-set media state inputs and the system clock
`timescale 1ns/100ps
module drive_model (
    input  wire mclk,
    input  wire unitSelN,
    input  wire spindleRunN,
    input  wire seekDir,
    input  wire stepN,
    input  wire writeEnableN,
    input  wire protect,
    input  wire hiDens,
    input  wire swapped,
    input  wire idStrap,
    output reg  rotationMarkN,
    output wire hiDensityN,
    output wire outerCylFlagN,
    output wire mediaLockN,
    output reg  readStream,
    output wire mediaSwappedN,
    output wire driveId,
    output int  cyl
);
    int rev = 0;
    initial begin
        cyl = 0;
        rotationMarkN = 1'h1;
        readStream = 1'h0;
    end
    always @(posedge stepN)
        if (!unitSelN)
            cyl <= seekDir ? (cyl > 0 ? cyl - 1 : 0) : cyl + 1;
    always @(posedge mclk) begin
        rev <= (rev == 999) ? 0 : rev + 1;
        rotationMarkN <= !(rev < 4 && !spindleRunN);
        readStream <= (!unitSelN && writeEnableN) ? rev[4] : !readStream;
    end
    assign outerCylFlagN = (cyl != 0);
    assign mediaLockN    = !protect;
    assign hiDensityN    = !hiDens;
    assign mediaSwappedN = !swapped;
    assign driveId       = idStrap;
endmodule

// ### tb/test_diskette_drive_interface.sv
// self-checking bench for the diskette drive interface
// assumes the drive model on the far side and one 50 MHz clock
`timescale 1ns/100ps
`include "diskette_regs.vh"
module test_diskette_drive_interface;
    logic        mclk = 0, rstn = 0, hsel = 0, hwrite = 0, dmaAck = 0, idStrap;
    logic        protect = 0, hiDens = 0, swapped = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'h2;
    logic [7:0]  dmaWData = 0;
    logic [10:0] v;
    wire         hreadyout, hresp, dmaReq, unitSelN, spindleRunN, densityMode, sideSel;
    wire         seekDir, stepN, writeEnableN, writeStream, rotationMarkN, hiDensityN;
    wire         outerCylFlagN, mediaLockN, readStream, mediaSwappedN, driveId;
    wire  [31:0] hrdata;
    wire  [7:0]  dmaRData;
    int          cyl, failures = 0, checked = 0, expCyl = 0, n;
    int          steps[$] = '{3, 5, 2};
    always #10 mclk = ~mclk;
    diskette_drive_interface #(.STEP_GAP_CYC(20)) dut (.mclk, .rstn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .dmaReq, .dmaAck, .dmaWData, .dmaRData, .unitSelN, .spindleRunN,
        .densityMode, .sideSel, .seekDir, .stepN, .writeEnableN, .writeStream,
        .rotationMarkN, .hiDensityN, .outerCylFlagN, .mediaLockN, .readStream,
        .mediaSwappedN, .driveId);
    drive_model drv (.mclk, .unitSelN, .spindleRunN, .seekDir, .stepN, .writeEnableN,
        .protect, .hiDens, .swapped, .idStrap, .rotationMarkN, .hiDensityN,
        .outerCylFlagN, .mediaLockN, .readStream, .mediaSwappedN, .driveId, .cyl);
    task automatic stop_test();
        if (failures == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_rdy();
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'h1 && n < 50);
        if (n >= 50) begin
            failures++;
            stop_test();
        end
    endtask
    task automatic bus(logic [31:0] a, logic w, logic [31:0] d);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= w;
        htrans <= `HTRANS_NONSEQ;
        wait_rdy();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        check("hresp", hresp, 1'h0);
    endtask
    initial begin
        n = $urandom(32'hf3a3);
        idStrap = 1'($urandom);
        repeat (20) @(posedge mclk);
        rstn <= 1'h1;
        @(posedge mclk);
        check("unitSelN", unitSelN, 1'h1);
        check("spindleRunN", spindleRunN, 1'h1);
        check("densityMode", densityMode, 1'h0);
        check("sideSel", sideSel, 1'h1);
        check("writeEnableN", writeEnableN, 1'h1);
        check("dmaRData", dmaRData, 8'h00);
        bus(32'h40, 1'h0, 32'h0);
        check("unmapped", rd, 32'h0);
        bus(`REG_STATUS, 1'h0, 32'h0);
        check("status", rd & 32'h007f0060, 32'h00400000);
        for (int i = 0; i < 8; i++) begin
            v = 11'($urandom);
            {protect, hiDens, swapped} <= 3'($urandom);
            repeat (6) @(posedge mclk);
            bus(`REG_CTRL, 1'h1, {21'h0, v});
            repeat (3) @(posedge mclk);
            check("unitSelN", unitSelN, !v[0]);
            check("spindleRunN", spindleRunN, !v[1]);
            check("densityMode", densityMode, v[2]);
            check("sideSel", sideSel, !v[3]);
            check("writeEnableN", writeEnableN, !(v[0] & v[5] & !protect));
            bus(`REG_STATUS, 1'h0, 32'h0);
            check("status", rd & 32'hde, {24'h0, idStrap, v[0] & v[5] & !protect, 1'h0,
                swapped, hiDens, protect, 2'h2});
            bus(`REG_CTRL, 1'h0, 32'h0);
            check("ctrl", rd[10:0], v);
        end
        protect <= 1'h0;
        repeat (6) @(posedge mclk);
        bus(`REG_CTRL, 1'h1, 32'h0a1);
        repeat (3) @(posedge mclk);
        check("dmaReq", dmaReq, 1'h1);
        check("writeStream", writeStream, 1'h0);
        bus(`REG_DATA, 1'h1, 32'hb2);
        for (n = 0; n < 60 && writeStream !== 1'h1; n++)
            @(posedge mclk);
        if (n >= 60) begin
            failures++;
            stop_test();
        end
        repeat (12) @(posedge mclk);
        for (int b = 6; b >= 0; b--) begin
            repeat (25) @(posedge mclk);
            check("writeStream", writeStream, (8'hb2 >> b) & 8'h01);
        end
        bus(`REG_CTRL, 1'h1, 32'h081);
        repeat (3) @(posedge mclk);
        check("dmaReq", dmaReq, 1'h0);
        repeat (400) @(posedge mclk);
        check("dmaReq", dmaReq, 1'h1);
        foreach (steps[i]) begin
            v = (i == 1) ? 11'h011 : (i == 2) ? 11'h000 : 11'h001;
            bus(`REG_CTRL, 1'h1, {21'h0, v});
            bus(`REG_STEP, 1'h1, steps[i]);
            if (v[0])
                expCyl = v[4] ? (expCyl > steps[i] ? expCyl - steps[i] : 0)
                              : expCyl + steps[i];
            repeat (4) @(posedge mclk);
            rd = 32'h20;
            for (int k = 0; k < 500 && rd[5]; k++)
                bus(`REG_STATUS, 1'h0, 32'h0);
            if (rd[5]) begin
                failures++;
                stop_test();
            end
            check("cylinder", cyl, expCyl);
            check("outer", rd[1], expCyl == 0);
        end
        stop_test();
    end
endmodule
